// ==== include/ccs_map.svh ====
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
// Notes on behaviour
// - One command port serves serial link and instrument bus alike.
// - Clear-status zeroes every event register feeding the status byte.
// - Clear-status drops pending output only when first in the line.
// - Event-enable set loads the mask from the integer's binary form.
// - Enable set outside 0..255 keeps the register and flags execution error.
// - Event-enable bit 4 enables the execution-error event.
// - Event-enable query returns the mask as a decimal integer.
// - Event-status query returns the flags in decimal, then clears them.
// - Identification returns maker, model, seven-digit serial, versions, comma separated.
// - Operation-complete command sets the operation-complete flag.
// - Operation-complete query queues the ASCII character 1.
// - Reset restores power-up state except interface, output queue, status byte, event flags, enable masks.
// - Service-request-enable set stores the value with bit six discarded.
// - Service-request-enable query returns the mask, bit six always zero.
// - Status-byte query returns the byte, bit six the master summary.
// - Trigger command starts one measurement.
// - Wait-to-continue is accepted and does nothing.
// - Interrupt character halts transfer and discards pending output.

// ==========================================
// Event flag bit positions
`define CCS_ESR_OPC      0
`define CCS_ESR_EXE      4
// ==========================================
// Status byte bit positions
`define CCS_STB_MAV      4
`define CCS_STB_ESB      5
`define CCS_STB_MSS      6
`define CCS_STB_EXT_MASK 8'h8F
// ==========================================
// Reset values and service-request keep mask
`define CCS_ESR_RST      8'h80
`define CCS_ESE_RST      8'h00
`define CCS_SRE_RST      8'h00
`define CCS_SRE_KEEP     8'hBF
// ==========================================
// Parameter range, characters and operation-complete reply value
`define CCS_PARAM_MIN    32'sh0000_0000
`define CCS_PARAM_MAX    32'sh0000_00FF
`define CCS_CHR_ZERO     8'h30
`define CCS_CHR_LF       8'h0A
`define CCS_OPC_REPLY    8'h01
`endif

// ==== include/ccs_pkg.sv ====
package ccs_pkg;
    // ==========================================
    // Decoded common commands
    typedef enum logic [3:0] {
        CCS_CMD_CLS     = 4'h0,
        CCS_CMD_ESE_SET = 4'h1,
        CCS_CMD_ESE_Q   = 4'h2,
        CCS_CMD_ESR_Q   = 4'h3,
        CCS_CMD_IDN_Q   = 4'h4,
        CCS_CMD_OPC_SET = 4'h5,
        CCS_CMD_OPC_Q   = 4'h6,
        CCS_CMD_RST     = 4'h7,
        CCS_CMD_SRE_SET = 4'h8,
        CCS_CMD_SRE_Q   = 4'h9,
        CCS_CMD_STB_Q   = 4'hA,
        CCS_CMD_TRG     = 4'hB,
        CCS_CMD_WAI     = 4'hC
    } ccs_cmd_e;

    // ==========================================
    // Response kinds and sender states
    typedef enum logic [0:0] {
        CCS_RSP_NUM = 1'b0,
        CCS_RSP_IDN = 1'b1
    } ccs_rsp_e;

    typedef enum logic [0:0] {
        CCS_ST_IDLE = 1'b0,
        CCS_ST_SEND = 1'b1
    } ccs_state_e;

    // ==========================================
    // Whole state of the unit
    typedef struct packed {
        ccs_state_e state;
        ccs_rsp_e   rsp_kind;
        logic [7:0] rsp_val;
        logic [5:0] rsp_idx;
        logic [7:0] event_enable_mask;
        logic [7:0] standard_event_flags;
        logic [7:0] service_request_mask;
        logic [7:0] stb;
        logic       out_valid;
        logic [7:0] out_data;
        logic       meas_trig;
        logic       soft_rst;
        logic       status_clr;
    } ccs_state_s;
endpackage

// ==== rtl/ccs_dec.sv ====
`timescale 1ns/1ps
// ==========================================
// Byte to three decimal digits
module ccs_dec (
    input  wire logic [7:0] val,
    output logic      [3:0] hund,
    output logic      [3:0] tens,
    output logic      [3:0] ones,
    output logic      [1:0] ndig
);
    logic [7:0] h_w;
    logic [7:0] rem_w;
    logic [7:0] t_w;
    logic [7:0] o_w;

    // Constant divisors, so synthesis folds these into small logic
    assign h_w   = val / 8'h64;
    assign rem_w = val - h_w * 8'h64;
    assign t_w   = rem_w / 8'h0A;
    assign o_w   = rem_w - t_w * 8'h0A;
    assign hund  = h_w[3:0];
    assign tens  = t_w[3:0];
    assign ones  = o_w[3:0];

    // Leading zeros are suppressed
    always_comb begin
        if (val >= 8'h64) begin
            ndig = 2'h3;
        end else if (val >= 8'h0A) begin
            ndig = 2'h2;
        end else begin
            ndig = 2'h1;
        end
    end
endmodule

// ==== rtl/ccs_unit.sv ====
`timescale 1ns/1ps
`include "ccs_map.svh"
// ==========================================
// Common command and status unit
module ccs_unit #(
    parameter int                  IDN_LEN  = 28,
    // Identity text is arbitrary: maker, model, serial, versions
    parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "MAKER,MODEL,0000001,1.0,D1.0"
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    cmd_valid,
    output logic                         cmd_ready,
    input  wire ccs_pkg::ccs_cmd_e       cmd_code,
    input  wire logic signed [31:0]      cmd_param,
    input  wire logic                    cmd_first,
    input  wire logic                    ctrl_c,
    input  wire logic [7:0]              ev_set,
    input  wire logic [7:0]              stb_ext,
    output logic                         out_valid,
    input  wire logic                    out_ready,
    output logic [7:0]                   out_data,
    output logic [7:0]                   status_byte,
    output logic                         srq,
    output logic                         meas_trig,
    output logic                         soft_rst,
    output logic                         status_clr
);
    // ==========================================
    // State registers
    ccs_pkg::ccs_state_s q_ff;
    ccs_pkg::ccs_state_s nxt_q;

    logic       busy;
    logic       accept;
    logic       is_query;
    logic       in_range;
    logic [7:0] ev_all;
    logic       esr_clr;
    logic [7:0] stb_nomss;
    logic       esb;
    logic       mss;
    logic [3:0] dig_h;
    logic [3:0] dig_t;
    logic [3:0] dig_o;
    logic [1:0] ndig;
    logic [5:0] rsp_len;
    logic [7:0] chr;
    logic [5:0] pos;

    // ==========================================
    // Decimal digits of the pending number
    ccs_dec u_dec (
        .val  (q_ff.rsp_val),
        .hund (dig_h),
        .tens (dig_t),
        .ones (dig_o),
        .ndig (ndig)
    );

    // ==========================================
    // Handshake and classification
    // Output queue holds a message while sending or while a byte waits
    assign busy = (q_ff.state == ccs_pkg::CCS_ST_SEND) || q_ff.out_valid;

    // Queries only wait for the queue; other commands never stall
    always_comb begin
        case (cmd_code)
            ccs_pkg::CCS_CMD_ESE_Q,
            ccs_pkg::CCS_CMD_ESR_Q,
            ccs_pkg::CCS_CMD_IDN_Q,
            ccs_pkg::CCS_CMD_OPC_Q,
            ccs_pkg::CCS_CMD_SRE_Q,
            ccs_pkg::CCS_CMD_STB_Q: is_query = 1'b1;
            default:                is_query = 1'b0;
        endcase
    end

    assign cmd_ready = !(busy && is_query);
    assign accept    = cmd_valid && cmd_ready;

    assign in_range = (cmd_param >= `CCS_PARAM_MIN) && (cmd_param <= `CCS_PARAM_MAX);

    // ==========================================
    // Status summary
    // execution error enabled by bit 4
    assign esb = |(q_ff.standard_event_flags & q_ff.event_enable_mask);

    always_comb begin
        stb_nomss                = stb_ext & `CCS_STB_EXT_MASK;
        stb_nomss[`CCS_STB_MAV]  = busy;
        stb_nomss[`CCS_STB_ESB]  = esb;
    end

    assign mss = |(stb_nomss & q_ff.service_request_mask & `CCS_SRE_KEEP);

    // ==========================================
    // Response character generator
    always_comb begin
        if (q_ff.rsp_kind == ccs_pkg::CCS_RSP_IDN) begin
            rsp_len = 6'(IDN_LEN);
        end else begin
            rsp_len = {4'h0, ndig};
        end
    end

    // Digit position counted from the least significant end
    assign pos = rsp_len - 6'h01 - q_ff.rsp_idx;

    always_comb begin
        chr = `CCS_CHR_LF;
        if (q_ff.rsp_idx < rsp_len) begin
            if (q_ff.rsp_kind == ccs_pkg::CCS_RSP_IDN) begin
                chr = IDN_TEXT[8*pos +: 8];
            end else if (pos == 6'h02) begin
                chr = `CCS_CHR_ZERO + {4'h0, dig_h};
            end else if (pos == 6'h01) begin
                chr = `CCS_CHR_ZERO + {4'h0, dig_t};
            end else begin
                chr = `CCS_CHR_ZERO + {4'h0, dig_o};
            end
        end
    end

    // ==========================================
    // Next-state logic
    always_comb begin
        nxt_q            = q_ff;
        nxt_q.meas_trig  = 1'b0;
        nxt_q.soft_rst   = 1'b0;
        nxt_q.status_clr = 1'b0;
        ev_all           = ev_set;
        esr_clr          = 1'b0;

        // Byte taken by the host frees the output register
        if (q_ff.out_valid && out_ready) begin
            nxt_q.out_valid = 1'b0;
        end

        // Next byte of the response, newline closes it
        if ((q_ff.state == ccs_pkg::CCS_ST_SEND) && !nxt_q.out_valid) begin
            nxt_q.out_valid = 1'b1;
            nxt_q.out_data  = chr;
            if (q_ff.rsp_idx == rsp_len) begin
                nxt_q.state = ccs_pkg::CCS_ST_IDLE;
            end else begin
                nxt_q.rsp_idx = q_ff.rsp_idx + 6'h01;
            end
        end

        if (accept) begin
            case (cmd_code)
                ccs_pkg::CCS_CMD_CLS: begin
                    esr_clr          = 1'b1;
                    nxt_q.status_clr = 1'b1;
                    if (cmd_first) begin
                        nxt_q.state     = ccs_pkg::CCS_ST_IDLE;
                        nxt_q.out_valid = 1'b0;
                    end
                end
                ccs_pkg::CCS_CMD_ESE_SET: begin
                    if (in_range) begin
                        nxt_q.event_enable_mask = cmd_param[7:0];
                    end else begin
                        ev_all[`CCS_ESR_EXE] = 1'b1;
                    end
                end
                ccs_pkg::CCS_CMD_SRE_SET: begin
                    if (in_range) begin
                        nxt_q.service_request_mask = cmd_param[7:0] & `CCS_SRE_KEEP;
                    end else begin
                        ev_all[`CCS_ESR_EXE] = 1'b1;
                    end
                end
                ccs_pkg::CCS_CMD_ESE_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_NUM;
                    nxt_q.rsp_val  = q_ff.event_enable_mask;
                    nxt_q.rsp_idx  = 6'h00;
                end
                ccs_pkg::CCS_CMD_ESR_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_NUM;
                    nxt_q.rsp_val  = q_ff.standard_event_flags;
                    nxt_q.rsp_idx  = 6'h00;
                    esr_clr        = 1'b1;
                end
                ccs_pkg::CCS_CMD_IDN_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_IDN;
                    nxt_q.rsp_val  = 8'h00;
                    nxt_q.rsp_idx  = 6'h00;
                end
                ccs_pkg::CCS_CMD_OPC_SET: begin
                    ev_all[`CCS_ESR_OPC] = 1'b1;
                end
                ccs_pkg::CCS_CMD_OPC_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_NUM;
                    nxt_q.rsp_val  = `CCS_OPC_REPLY;
                    nxt_q.rsp_idx  = 6'h00;
                end
                ccs_pkg::CCS_CMD_RST: begin
                    // masks, flags and status byte kept
                    nxt_q.soft_rst = 1'b1;
                end
                ccs_pkg::CCS_CMD_SRE_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_NUM;
                    nxt_q.rsp_val  = q_ff.service_request_mask & `CCS_SRE_KEEP;
                    nxt_q.rsp_idx  = 6'h00;
                end
                ccs_pkg::CCS_CMD_STB_Q: begin
                    nxt_q.state    = ccs_pkg::CCS_ST_SEND;
                    nxt_q.rsp_kind = ccs_pkg::CCS_RSP_NUM;
                    nxt_q.rsp_val  = q_ff.stb;
                    nxt_q.rsp_idx  = 6'h00;
                end
                ccs_pkg::CCS_CMD_TRG: begin
                    nxt_q.meas_trig = 1'b1;
                end
                default: begin
                    nxt_q.state = nxt_q.state;
                end
            endcase
        end

        if (ctrl_c) begin
            nxt_q.state     = ccs_pkg::CCS_ST_IDLE;
            nxt_q.out_valid = 1'b0;
        end

        // Set wins over clear so no event is lost
        nxt_q.standard_event_flags = (esr_clr ? 8'h00 : q_ff.standard_event_flags) | ev_all;

        // Registered status byte, one cycle behind its sources
        nxt_q.stb               = stb_nomss;
        nxt_q.stb[`CCS_STB_MSS] = mss;
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_ff            <= '0;
            q_ff.event_enable_mask        <= `CCS_ESE_RST;
            q_ff.standard_event_flags        <= `CCS_ESR_RST;
            q_ff.service_request_mask        <= `CCS_SRE_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ==========================================
    // Outputs, all from flip-flops except the ready
    assign out_valid   = q_ff.out_valid;
    assign out_data    = q_ff.out_data;
    assign status_byte = q_ff.stb;
    assign srq         = q_ff.stb[`CCS_STB_MSS];
    assign meas_trig   = q_ff.meas_trig;
    assign soft_rst    = q_ff.soft_rst;
    assign status_clr  = q_ff.status_clr;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Event-enable load
    AST_ESE_LOAD: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_ESE_SET && in_range
        |=> q_ff.event_enable_mask == $past(cmd_param[7:0]))
        else $error("event enable mask not loaded");

    // Out of range keeps masks and flags an error
    AST_RANGE_ERR: assert property (
        accept && !in_range && (cmd_code == ccs_pkg::CCS_CMD_ESE_SET
        || cmd_code == ccs_pkg::CCS_CMD_SRE_SET)
        |=> q_ff.standard_event_flags[`CCS_ESR_EXE] && $stable(q_ff.event_enable_mask) && $stable(q_ff.service_request_mask))
        else $error("range error not handled");

    // Event flags cleared after the query
    AST_ESR_CLEAR: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_ESR_Q && ev_set == 8'h00
        |=> q_ff.standard_event_flags == 8'h00)
        else $error("event flags not cleared by query");

    // Operation complete flag
    AST_OPC_SET: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_OPC_SET
        |=> q_ff.standard_event_flags[`CCS_ESR_OPC])
        else $error("operation complete flag not set");

    // Operation complete query yields a one
    AST_OPC_REPLY: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_OPC_Q ##1 !ctrl_c
        |=> out_valid && out_data == 8'h31 ##0 (!ctrl_c && out_ready)
        |=> out_valid && out_data == `CCS_CHR_LF)
        else $error("operation complete reply wrong");

    // Service request mask bit six never held
    AST_SRE_B6: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_SRE_SET && in_range
        |=> q_ff.service_request_mask == ($past(cmd_param[7:0]) & 8'hBF))
        else $error("service request mask wrong");

    // Trigger is a single pulse
    AST_TRG: assert property (
        accept && cmd_code == ccs_pkg::CCS_CMD_TRG
        |=> meas_trig ##1 (!meas_trig || $past(accept)))
        else $error("trigger pulse wrong");

    // Interrupt character empties the output queue
    AST_CTRLC: assert property (
        ctrl_c |=> !out_valid && !busy)
        else $error("output not discarded");

    // Event summary tracks enabled flags
    AST_ESB: assert property (
        1'b1 |=> status_byte[`CCS_STB_ESB] == $past(|(q_ff.standard_event_flags & q_ff.event_enable_mask)))
        else $error("event summary bit wrong");

    // Service request only with an enabled cause
    AST_MSS: assert property (
        srq |-> |($past(stb_nomss) & $past(q_ff.service_request_mask) & 8'hBF))
        else $error("service request without cause");
endmodule

// ==== tb/ccs_host.sv ====
`timescale 1ns/1ps
// ==========================================
// Remote host model: takes response bytes
module ccs_host (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic       out_valid,
    output logic            out_ready,
    input  wire logic [7:0] out_data
);
    // Bytes taken so far, read back by the bench
    logic [7:0] rx_q[$];

    // ==========================================
    // Byte sink
    // Mode 0 takes every cycle, 1 every other cycle, 2 stalls outright
    // each reply line is closed by a newline byte
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                rx_q.push_back(out_data);
            end
            out_ready <= (mode == 2'h0) ? 1'b1 : ((mode == 2'h1) ? ~out_ready : 1'b0);
        end
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "ccs_map.svh"
module tb_top;
    localparam int                   IDN_LEN  = 28;
    // Identity text is arbitrary
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME0,UNIT9,1234567,2.1,D3.4";

    logic                clk_sys = 1'b0;
    logic                rst;
    logic                cmd_valid;
    logic                cmd_ready;
    ccs_pkg::ccs_cmd_e   cmd_code;
    logic signed [31:0]  cmd_param;
    logic                cmd_first;
    logic                ctrl_c;
    logic [7:0]          ev_set;
    logic [7:0]          stb_ext;
    logic                out_valid;
    logic                out_ready;
    logic [7:0]          out_data;
    logic [7:0]          status_byte;
    logic                srq;
    logic                meas_trig;
    logic                soft_rst;
    logic                status_clr;
    logic [1:0]          mode;
    int                  bad_count = 0;
    int                  checks_done = 0;
    int                  n_trig = 0;
    int                  n_srst = 0;
    int                  n_clr = 0;

    // ==========================================
    // Clock, instances
    always #5 clk_sys = ~clk_sys;

    ccs_unit #(.IDN_LEN(IDN_LEN), .IDN_TEXT(IDN_TEXT)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_param(cmd_param), .cmd_first(cmd_first),
        .ctrl_c(ctrl_c), .ev_set(ev_set), .stb_ext(stb_ext), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .status_byte(status_byte),
        .srq(srq), .meas_trig(meas_trig), .soft_rst(soft_rst), .status_clr(status_clr)
    );

    ccs_host host_u (
        .clk_sys(clk_sys), .rst(rst), .mode(mode), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data)
    );

    // Pulse counters, so a pulse of any width is caught
    always @(posedge clk_sys) begin
        if (meas_trig === 1'b1) n_trig <= n_trig + 1;
        if (soft_rst === 1'b1) n_srst <= n_srst + 1;
        if (status_clr === 1'b1) n_clr <= n_clr + 1;
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Hold the command until cmd_ready is seen high at an edge
    task automatic send(input ccs_pkg::ccs_cmd_e c, input int p, input logic f);
        int n;
        n = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_param <= p;
        cmd_first <= f;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 500);
        cmd_valid <= 1'b0;
    endtask

    task automatic expect_text(input string s);
        int n;
        n = 0;
        while (host_u.rx_q.size() < s.len() && n < 800) begin
            @(posedge clk_sys);
            n++;
        end
        wait_clk(4);
        check(host_u.rx_q.size(), s.len(), "reply length");
        for (int i = 0; i < s.len(); i++) begin
            check(host_u.rx_q[i], s[i], "reply byte");
        end
        host_u.rx_q.delete();
    endtask

    // Query answered as a decimal line with no leading zeros
    task automatic q(input ccs_pkg::ccs_cmd_e c, input int v);
        send(c, 0, 1'b1);
        expect_text($sformatf("%0d\n", v));
    endtask

    task automatic pulse_ev(input logic [7:0] v);
        @(posedge clk_sys);
        ev_set <= v;
        @(posedge clk_sys);
        ev_set <= 8'h00;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_power_on();
        q(ccs_pkg::CCS_CMD_ESR_Q, `CCS_ESR_RST);
        q(ccs_pkg::CCS_CMD_ESR_Q, 0);
        q(ccs_pkg::CCS_CMD_ESE_Q, 0);
        q(ccs_pkg::CCS_CMD_SRE_Q, 0);
    endtask

    // Out-of-range values on both sides of the limits
    task automatic t_event_enable();
        send(ccs_pkg::CCS_CMD_ESE_SET, 16, 1'b1);
        q(ccs_pkg::CCS_CMD_ESE_Q, 16);
        send(ccs_pkg::CCS_CMD_ESE_SET, 256, 1'b1);
        send(ccs_pkg::CCS_CMD_ESE_SET, -1, 1'b1);
        q(ccs_pkg::CCS_CMD_ESE_Q, 16);
        wait_clk(3);
        check(status_byte[5], 1'b1, "event summary on");
        q(ccs_pkg::CCS_CMD_ESR_Q, 16);
        wait_clk(3);
        check(status_byte[5], 1'b0, "event summary off");
    endtask

    task automatic t_service();
        send(ccs_pkg::CCS_CMD_SRE_SET, 255, 1'b1);
        q(ccs_pkg::CCS_CMD_SRE_Q, 191);
        send(ccs_pkg::CCS_CMD_SRE_SET, 300, 1'b1);
        q(ccs_pkg::CCS_CMD_SRE_Q, 191);
        q(ccs_pkg::CCS_CMD_ESR_Q, 16);
        @(posedge clk_sys);
        stb_ext <= 8'h01;
        wait_clk(3);
        check(srq, 1'b1, "service request");
        check(status_byte, 8'h41, "status byte");
        q(ccs_pkg::CCS_CMD_STB_Q, 65);
        @(posedge clk_sys);
        stb_ext <= 8'h70;
        wait_clk(3);
        check(status_byte, 8'h00, "ignored inputs");
        check(srq, 1'b0, "no request");
        send(ccs_pkg::CCS_CMD_SRE_SET, 0, 1'b1);
    endtask

    task automatic t_opc();
        send(ccs_pkg::CCS_CMD_OPC_SET, 0, 1'b1);
        q(ccs_pkg::CCS_CMD_ESR_Q, 1);
        mode <= 2'h1;
        q(ccs_pkg::CCS_CMD_OPC_Q, 1);
        mode <= 2'h0;
    endtask

    // Pending reply survives a later clear, dies on a first-in-line clear
    task automatic t_clear();
        int c0;
        c0 = n_clr;
        mode <= 2'h2;
        pulse_ev(8'h04);
        send(ccs_pkg::CCS_CMD_OPC_Q, 0, 1'b1);
        wait_clk(4);
        check(status_byte[4], 1'b1, "message available");
        send(ccs_pkg::CCS_CMD_CLS, 0, 1'b0);
        wait_clk(3);
        check(n_clr, c0 + 1, "clear pulse");
        mode <= 2'h0;
        expect_text("1\n");
        q(ccs_pkg::CCS_CMD_ESR_Q, 0);
        mode <= 2'h2;
        send(ccs_pkg::CCS_CMD_OPC_Q, 0, 1'b1);
        wait_clk(4);
        send(ccs_pkg::CCS_CMD_CLS, 0, 1'b1);
        wait_clk(3);
        check(out_valid, 1'b0, "reply dropped");
        mode <= 2'h0;
        wait_clk(10);
        check(host_u.rx_q.size(), 0, "no bytes");
        check(status_byte[4], 1'b0, "nothing pending");
    endtask

    task automatic t_misc();
        int a;
        int b;
        int c;
        send(ccs_pkg::CCS_CMD_ESE_SET, 8, 1'b1);
        send(ccs_pkg::CCS_CMD_OPC_SET, 0, 1'b1);
        a = n_trig;
        b = n_srst;
        c = n_clr;
        send(ccs_pkg::CCS_CMD_TRG, 0, 1'b1);
        wait_clk(3);
        check(n_trig, a + 1, "one trigger");
        send(ccs_pkg::CCS_CMD_RST, 0, 1'b1);
        wait_clk(3);
        check(n_srst, b + 1, "one soft reset");
        q(ccs_pkg::CCS_CMD_ESE_Q, 8);
        q(ccs_pkg::CCS_CMD_ESR_Q, 1);
        send(ccs_pkg::CCS_CMD_WAI, 0, 1'b1);
        wait_clk(3);
        check(n_trig + n_srst + n_clr, a + b + c + 2, "no pulses");
        q(ccs_pkg::CCS_CMD_ESE_Q, 8);
    endtask

    // Five comma separated fields, slow host
    task automatic t_identity();
        mode <= 2'h1;
        send(ccs_pkg::CCS_CMD_IDN_Q, 0, 1'b1);
        expect_text($sformatf("%s\n", IDN_TEXT));
        mode <= 2'h0;
    endtask

    // Interrupt in mid-reply; later queries still answered
    task automatic t_break();
        int n;
        n = 0;
        mode <= 2'h1;
        send(ccs_pkg::CCS_CMD_IDN_Q, 0, 1'b1);
        while (host_u.rx_q.size() < 5 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        ctrl_c <= 1'b1;
        @(posedge clk_sys);
        ctrl_c <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(out_valid, 1'b0, "output halted");
        mode <= 2'h0;
        wait_clk(10);
        check(host_u.rx_q.size() < 10, 1'b1, "reply cut");
        host_u.rx_q.delete();
        q(ccs_pkg::CCS_CMD_OPC_Q, 1);
    endtask

    // ==========================================
    // Verdict, watchdog, main sequence
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run takes a few hundred cycles
    initial begin
        wait_clk(30000);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        rst       = 1'b1;
        cmd_valid = 1'b0;
        cmd_code  = ccs_pkg::CCS_CMD_WAI;
        cmd_param = 32'sh0;
        cmd_first = 1'b0;
        ctrl_c    = 1'b0;
        ev_set    = 8'h00;
        stb_ext   = 8'h00;
        mode      = 2'h0;
        wait_clk(20);
        rst <= 1'b0;
        t_power_on();
        t_event_enable();
        t_service();
        t_opc();
        t_clear();
        t_misc();
        t_identity();
        t_break();
        finish_test();
    end
endmodule
